// file: hdl/event_timer_pkg.sv
package event_timer_pkg;
	// Sizes
	localparam int NUM_EVT = 16;
	localparam int NUM_CNT = 2;
	localparam int NUM_CHAN = 6;
	localparam int CNT_W = 32;

	// Register offsets (byte addresses)
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_EVT_INV = 8'h04;
	localparam logic [7:0] ADDR_OUT_CFG = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_GATE = 8'h10;
	localparam logic [7:0] ADDR_CNT_CMD = 8'h14;
	localparam logic [7:0] ADDR_CNT_BASE = 8'h20;
	localparam logic [7:0] CNT_STRIDE = 8'h10;
	localparam logic [7:0] CNT_CFG_OFS = 8'h00;
	localparam logic [7:0] CNT_MAX_OFS = 8'h04;
	localparam logic [7:0] CNT_RES_OFS = 8'h08;
	localparam logic [7:0] CNT_LIVE_OFS = 8'h0c;

	// Field positions
	localparam int CTRL_WIDE_BIT = 0;
	localparam int CTRL_START_FALL_BIT = 1;
	localparam int CTRL_STOP_FALL_BIT = 2;
	localparam int CTRL_SW_START_BIT = 3;
	localparam int CTRL_SW_STOP_BIT = 4;
	localparam int CTRL_PAUSE_BIT = 5;
	localparam int OUT1_LSB = 0;
	localparam int OUT2_LSB = 2;
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_POLICY_LSB = 4;
	localparam int CFG_RST_INV_BIT = 6;
	localparam int STATUS_REC_BIT = 16;
	localparam int STATUS_OUT1_BIT = 17;
	localparam int STATUS_OUT2_BIT = 18;

	// Pin sharing: counter k uses event pins 4k (signal/A), 4k+1 (direction/B), 4k+2 (reset)
	localparam int CNT_PIN_STRIDE = 4;
	localparam int SIG_PIN_OFS = 0;
	localparam int AUX_PIN_OFS = 1;
	localparam int RST_PIN_OFS = 2;
	localparam int START_PIN = 14;
	localparam int STOP_PIN = 15;

	// Reset values and unsigned count limit
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] GATE_RESET = 32'h0000_0001;
	localparam logic [31:0] MAX_RESET = 32'h0000_0168;
	localparam logic [31:0] UNI_LIMIT = 32'h8000_0000;

	// Timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int EVT_DELAY_US = 200;
	localparam int PULSE_MIN_NS = 12800;
	localparam int REC_DELAY_NS = 450;
	localparam int EVT_DELAY_CYC = EVT_DELAY_US * 1000000 / CLK_PERIOD_PS;
	localparam int PULSE_CYC = (PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int REC_DELAY_CYC = REC_DELAY_NS * 1000 / CLK_PERIOD_PS;

	typedef enum logic [1:0] {
		OUT1_LOW = 2'b00,
		OUT1_HIGH = 2'b01,
		OUT1_TRIG = 2'b10,
		OUT1_ALARM = 2'b11
	} out1_mode_e;

	typedef enum logic [2:0] {
		MODE_UNI_COUNT = 3'b000,
		MODE_BI_COUNT = 3'b001,
		MODE_QUAD = 3'b010,
		MODE_ANGLE = 3'b011,
		MODE_UNI_FREQ = 3'b100,
		MODE_BI_FREQ = 3'b101
	} cnt_mode_e;

	typedef enum logic [1:0] {
		RST_MANUAL = 2'b00,
		RST_START = 2'b01,
		RST_FIRST = 2'b10,
		RST_EACH = 2'b11
	} rst_policy_e;
endpackage

// file: hdl/timer_counter_channel.sv
`timescale 1ns/1ps
module timer_counter_channel
	import event_timer_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic enable_i,
	input wire logic [2:0] mode_i,
	input wire logic [1:0] policy_i,
	input wire logic rst_invert_i,
	input wire logic [31:0] max_count_i,
	input wire logic sig_i,
	input wire logic aux_i,
	input wire logic ext_rst_i,
	input wire logic rec_start_i,
	input wire logic recording_i,
	input wire logic sw_clear_i,
	input wire logic gate_tick_i,
	output logic [31:0] live_o,
	output logic [31:0] result_o
);
	logic sig_prev_reg;
	logic aux_prev_reg;
	logic rst_prev_reg;
	logic first_done_reg;
	logic [31:0] count_reg;
	logic [31:0] count_next;
	logic [31:0] result_reg;
	logic sig_rise;
	logic aux_chg;
	logic sig_chg;
	logic rst_lvl;
	logic rst_pulse;
	logic clear;
	logic is_freq;

	// Previous levels for edge detection
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sig_prev_reg <= 1'b0;
			aux_prev_reg <= 1'b0;
			rst_prev_reg <= 1'b0;
		end else begin
			sig_prev_reg <= sig_i;
			aux_prev_reg <= aux_i;
			rst_prev_reg <= rst_lvl;
		end
	end

	assign rst_lvl = ext_rst_i ^ rst_invert_i;
	assign rst_pulse = rst_lvl & ~rst_prev_reg;
	assign sig_rise = sig_i & ~sig_prev_reg;
	assign sig_chg = sig_i ^ sig_prev_reg;
	assign aux_chg = aux_i ^ aux_prev_reg;
	assign is_freq = (mode_i == MODE_UNI_FREQ) || (mode_i == MODE_BI_FREQ);

	// Only the first reset pulse of a recording is honoured in that policy
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			first_done_reg <= 1'b0;
		end else if (rec_start_i) begin
			first_done_reg <= 1'b0;
		end else if (rst_pulse && recording_i) begin
			first_done_reg <= 1'b1;
		end
	end

	// Clear request by selected policy; angle re-zeros on any reset pulse
	always_comb begin
		clear = 1'b0;
		if (mode_i == MODE_ANGLE) begin
			clear = rst_pulse;
		end else begin
			unique case (policy_i)
				RST_MANUAL: clear = sw_clear_i;
				RST_START: clear = rec_start_i;
				RST_FIRST: clear = rst_pulse && recording_i && !first_done_reg;
				RST_EACH: clear = rst_pulse;
			endcase
		end
	end

	// Step the count by mode
	always_comb begin
		count_next = count_reg;
		unique case (mode_i)
			MODE_UNI_COUNT, MODE_UNI_FREQ: begin
				if (sig_rise && count_reg != UNI_LIMIT) begin
					count_next = count_reg + 32'h1;
				end
			end
			MODE_BI_COUNT, MODE_BI_FREQ: begin
				if (sig_rise) begin
					count_next = aux_i ? count_reg - 32'h1 : count_reg + 32'h1;
				end
			end
			MODE_QUAD: begin
				// Both phases moving at once is an illegal step and is dropped
				if (sig_chg && !aux_chg) begin
					count_next = (sig_i ^ aux_i) ? count_reg + 32'h1 : count_reg - 32'h1;
				end else if (aux_chg && !sig_chg) begin
					count_next = (sig_i == aux_i) ? count_reg + 32'h1 : count_reg - 32'h1;
				end
			end
			MODE_ANGLE: begin
				if (sig_rise) begin
					count_next = (count_reg + 32'h1 >= max_count_i) ? 32'h0 : count_reg + 32'h1;
				end
			end
			default: count_next = count_reg;
		endcase
	end

	// Live counter; frequency modes restart every gate interval
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count_reg <= 32'h0;
		end else if (!enable_i || clear || (is_freq && gate_tick_i)) begin
			count_reg <= 32'h0;
		end else begin
			count_reg <= count_next;
		end
	end

	// Result latched once per gate interval
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			result_reg <= 32'h0;
		end else if (gate_tick_i) begin
			result_reg <= count_reg;
		end
	end

	assign live_o = count_reg;
	assign result_o = result_reg;
endmodule

// file: hdl/event_timer_counter_unit.sv
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
// Overview of operation
// - Sixteen event inputs, each optionally inverted
// - Output one: trigger, alarm, high or low
// - Output two: recording active, high or low
// - Trigger pulse 12.8 us, 200 us late
// - Alarm level follows conditions 200 us late
// - Recording level on output two follows state 450 ns late
// - Static level follows software write
// - Two counters, only in 32-bit storage mode
// - Count, quadrature, angle, frequency modes per counter
// - Selected edges start and stop recording
// - Signal, reset, direction inputs per counter
// - Unsigned to 2^31, signed bi-directional range
// - Result updated once per gate interval
// - Reset input level invertible
// - Manual policy clears on software command
// - Start policy clears at recording start
// - First-pulse policy honours only first pulse
// - Every-pulse policy clears on each pulse
// - Direction low counts up, high down
// - Angle wraps at maximum, reset re-zeros
module event_timer_counter_unit
	import event_timer_pkg::*;
#(
	parameter int EVT_DELAY = event_timer_pkg::EVT_DELAY_CYC
)(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic [event_timer_pkg::NUM_EVT-1:0] evt_pin_i,
	input wire logic [event_timer_pkg::NUM_CHAN-1:0] chan_trig_i,
	input wire logic [event_timer_pkg::NUM_CHAN-1:0] chan_alarm_i,
	input wire logic sample_tick_i,
	output logic out_evt1_o,
	output logic out_evt2_o,
	output logic recording_o
);
	import event_timer_pkg::*;

	localparam int DLY_W = $clog2(EVT_DELAY + 1);
	localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(EVT_DELAY - 1);
	localparam logic [11:0] PULSE_LAST = 12'(PULSE_CYC - 1);
	localparam logic [6:0] REC_LAST = 7'(REC_DELAY_CYC - 1);

	logic [31:0] ctrl_reg;
	logic [15:0] inv_reg;
	logic [3:0] out_cfg_reg;
	logic [31:0] gate_reg;
	logic [6:0] cfg_reg [NUM_CNT];
	logic [31:0] max_reg [NUM_CNT];
	logic [NUM_CNT-1:0] sw_clear_reg;
	logic [NUM_EVT-1:0] sync1_reg;
	logic [NUM_EVT-1:0] sync2_reg;
	logic [NUM_EVT-1:0] evt_lvl;
	logic start_prev_reg;
	logic stop_prev_reg;
	logic start_edge;
	logic stop_edge;
	logic recording_reg;
	logic rec_start;
	logic [31:0] gate_cnt_reg;
	logic gate_tick;
	logic trig_wait_reg;
	logic [DLY_W-1:0] trig_cnt_reg;
	logic pulse_reg;
	logic [11:0] pulse_cnt_reg;
	logic alarm_out_reg;
	logic [DLY_W-1:0] alarm_cnt_reg;
	logic rec_out_reg;
	logic [6:0] rec_cnt_reg;
	logic out1_reg;
	logic out2_reg;
	logic [31:0] rdata_reg;
	logic [31:0] live [NUM_CNT];
	logic [31:0] result [NUM_CNT];
	logic any_trig;
	logic any_alarm;
	logic rec_level;

	// Two-flop synchronisers; the first stage feeds only the second
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= evt_pin_i;
			sync2_reg <= sync1_reg;
		end
	end

	// Per-pin programmable inversion
	genvar gi;
	generate
		for (gi = 0; gi < NUM_EVT; gi++) begin : g_inv
			assign evt_lvl[gi] = sync2_reg[gi] ^ inv_reg[gi];
		end
	endgenerate

	// Register writes; software start, stop and counter clear are self-clearing
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl_reg <= CTRL_RESET;
			inv_reg <= 16'h0;
			out_cfg_reg <= 4'h0;
			gate_reg <= GATE_RESET;
			sw_clear_reg <= '0;
		end else begin
			ctrl_reg[CTRL_SW_START_BIT] <= 1'b0;
			ctrl_reg[CTRL_SW_STOP_BIT] <= 1'b0;
			sw_clear_reg <= '0;
			if (wr_i) begin
				unique case (addr_i)
					ADDR_CTRL: ctrl_reg <= {26'h0, wdata_i[5:0]};
					ADDR_EVT_INV: inv_reg <= wdata_i[15:0];
					ADDR_OUT_CFG: out_cfg_reg <= wdata_i[3:0];
					ADDR_GATE: gate_reg <= (wdata_i == 32'h0) ? GATE_RESET : wdata_i;
					ADDR_CNT_CMD: sw_clear_reg <= wdata_i[NUM_CNT-1:0];
					default: ;
				endcase
			end
		end
	end

	// Per-counter configuration and angle maximum
	generate
		for (gi = 0; gi < NUM_CNT; gi++) begin : g_cfg
			localparam logic [7:0] BASE = 8'(ADDR_CNT_BASE + gi * CNT_STRIDE);
			always_ff @(posedge clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					cfg_reg[gi] <= 7'h0;
					max_reg[gi] <= MAX_RESET;
				end else if (wr_i && addr_i == BASE + CNT_CFG_OFS) begin
					cfg_reg[gi] <= wdata_i[6:0];
				end else if (wr_i && addr_i == BASE + CNT_MAX_OFS) begin
					max_reg[gi] <= wdata_i;
				end
			end
		end
	endgenerate

	// Start and stop edge detection with selectable polarity
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			start_prev_reg <= 1'b0;
			stop_prev_reg <= 1'b0;
		end else begin
			start_prev_reg <= evt_lvl[START_PIN];
			stop_prev_reg <= evt_lvl[STOP_PIN];
		end
	end

	assign start_edge = ctrl_reg[CTRL_START_FALL_BIT] ? (start_prev_reg & ~evt_lvl[START_PIN])
		: (~start_prev_reg & evt_lvl[START_PIN]);
	assign stop_edge = ctrl_reg[CTRL_STOP_FALL_BIT] ? (stop_prev_reg & ~evt_lvl[STOP_PIN])
		: (~stop_prev_reg & evt_lvl[STOP_PIN]);
	assign rec_start = !recording_reg && (start_edge || ctrl_reg[CTRL_SW_START_BIT]);

	// Recording state; a stop in the same cycle as a start wins
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			recording_reg <= 1'b0;
		end else if (stop_edge || ctrl_reg[CTRL_SW_STOP_BIT]) begin
			recording_reg <= 1'b0;
		end else if (rec_start) begin
			recording_reg <= 1'b1;
		end
	end

	// Gate interval counted in sample periods, not clocks
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			gate_cnt_reg <= 32'h0;
		end else if (sample_tick_i) begin
			gate_cnt_reg <= gate_tick ? 32'h0 : gate_cnt_reg + 32'h1;
		end
	end

	assign gate_tick = sample_tick_i && (gate_cnt_reg >= gate_reg - 32'h1);

	// Counter channels on shared event pins
	generate
		for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
			timer_counter_channel u_chan (
				.clk_i(clk_i),
				.reset_n_i(reset_n_i),
				.enable_i(ctrl_reg[CTRL_WIDE_BIT]),
				.mode_i(cfg_reg[gi][CFG_MODE_LSB +: 3]),
				.policy_i(cfg_reg[gi][CFG_POLICY_LSB +: 2]),
				.rst_invert_i(cfg_reg[gi][CFG_RST_INV_BIT]),
				.max_count_i(max_reg[gi]),
				.sig_i(evt_lvl[gi * CNT_PIN_STRIDE + SIG_PIN_OFS]),
				.aux_i(evt_lvl[gi * CNT_PIN_STRIDE + AUX_PIN_OFS]),
				.ext_rst_i(evt_lvl[gi * CNT_PIN_STRIDE + RST_PIN_OFS]),
				.rec_start_i(rec_start),
				.recording_i(recording_reg),
				.sw_clear_i(sw_clear_reg[gi]),
				.gate_tick_i(gate_tick),
				.live_o(live[gi]),
				.result_o(result[gi])
			);
		end
	endgenerate

	assign any_trig = |chan_trig_i;
	assign any_alarm = |chan_alarm_i;

	// Trigger delay; trigger rate is low enough that one timer suffices
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			trig_wait_reg <= 1'b0;
			trig_cnt_reg <= '0;
		end else if (trig_wait_reg) begin
			trig_cnt_reg <= trig_cnt_reg + DLY_W'(1);
			if (trig_cnt_reg == DLY_LAST) begin
				trig_wait_reg <= 1'b0;
			end
		end else if (any_trig) begin
			trig_wait_reg <= 1'b1;
			trig_cnt_reg <= '0;
		end
	end

	// Fixed-width output pulse after the delay
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pulse_reg <= 1'b0;
			pulse_cnt_reg <= 12'h0;
		end else if (trig_wait_reg && trig_cnt_reg == DLY_LAST) begin
			pulse_reg <= 1'b1;
			pulse_cnt_reg <= 12'h0;
		end else if (pulse_reg) begin
			pulse_cnt_reg <= pulse_cnt_reg + 12'h1;
			if (pulse_cnt_reg == PULSE_LAST) begin
				pulse_reg <= 1'b0;
			end
		end
	end

	// Alarm follows after the level has held for the delay; shorter blips are dropped
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			alarm_out_reg <= 1'b0;
			alarm_cnt_reg <= '0;
		end else if (any_alarm == alarm_out_reg) begin
			alarm_cnt_reg <= '0;
		end else if (alarm_cnt_reg == DLY_LAST) begin
			alarm_out_reg <= any_alarm;
			alarm_cnt_reg <= '0;
		end else begin
			alarm_cnt_reg <= alarm_cnt_reg + DLY_W'(1);
		end
	end

	assign rec_level = recording_reg && !ctrl_reg[CTRL_PAUSE_BIT];

	// Recording-active output delayed by a fixed count
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rec_out_reg <= 1'b0;
			rec_cnt_reg <= 7'h0;
		end else if (rec_level == rec_out_reg) begin
			rec_cnt_reg <= 7'h0;
		end else if (rec_cnt_reg == REC_LAST) begin
			rec_out_reg <= rec_level;
			rec_cnt_reg <= 7'h0;
		end else begin
			rec_cnt_reg <= rec_cnt_reg + 7'h1;
		end
	end

	// Output line selection
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			out1_reg <= 1'b0;
			out2_reg <= 1'b0;
		end else begin
			unique case (out_cfg_reg[OUT1_LSB +: 2])
				OUT1_LOW: out1_reg <= 1'b0;
				OUT1_HIGH: out1_reg <= 1'b1;
				OUT1_TRIG: out1_reg <= pulse_reg;
				OUT1_ALARM: out1_reg <= alarm_out_reg;
			endcase
			unique case (out_cfg_reg[OUT2_LSB +: 2])
				2'b01: out2_reg <= 1'b1;
				2'b10: out2_reg <= rec_out_reg;
				default: out2_reg <= 1'b0;
			endcase
		end
	end

	// Read data one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_reg <= 32'h0;
		end else if (rd_i) begin
			rdata_reg <= 32'h0;
			unique case (addr_i)
				ADDR_CTRL: rdata_reg <= ctrl_reg;
				ADDR_EVT_INV: rdata_reg <= {16'h0, inv_reg};
				ADDR_OUT_CFG: rdata_reg <= {28'h0, out_cfg_reg};
				ADDR_STATUS: rdata_reg <= {13'h0, out2_reg, out1_reg, recording_reg, evt_lvl};
				ADDR_GATE: rdata_reg <= gate_reg;
				ADDR_CNT_BASE + CNT_CFG_OFS: rdata_reg <= {25'h0, cfg_reg[0]};
				ADDR_CNT_BASE + CNT_MAX_OFS: rdata_reg <= max_reg[0];
				ADDR_CNT_BASE + CNT_RES_OFS: rdata_reg <= result[0];
				ADDR_CNT_BASE + CNT_LIVE_OFS: rdata_reg <= live[0];
				ADDR_CNT_BASE + CNT_STRIDE + CNT_CFG_OFS: rdata_reg <= {25'h0, cfg_reg[1]};
				ADDR_CNT_BASE + CNT_STRIDE + CNT_MAX_OFS: rdata_reg <= max_reg[1];
				ADDR_CNT_BASE + CNT_STRIDE + CNT_RES_OFS: rdata_reg <= result[1];
				ADDR_CNT_BASE + CNT_STRIDE + CNT_LIVE_OFS: rdata_reg <= live[1];
				default: rdata_reg <= 32'h0;
			endcase
		end
	end

	assign rdata_o = rdata_reg;
	assign out_evt1_o = out1_reg;
	assign out_evt2_o = out2_reg;
	assign recording_o = recording_reg;

	// Checks on the block's own behaviour
	sequence s_trig_seen;
		!trig_wait_reg && any_trig;
	endsequence

	property p_trig_delay;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_trig_seen |=> trig_wait_reg [*8];
	endproperty
	a_trig_delay: assert property (p_trig_delay) else $error("trigger delay ended early");

	property p_pulse_start;
		@(posedge clk_i) disable iff (!reset_n_i)
		(trig_wait_reg && trig_cnt_reg == DLY_LAST) |=> pulse_reg [*8];
	endproperty
	a_pulse_start: assert property (p_pulse_start) else $error("trigger pulse too short");

	property p_pulse_len;
		@(posedge clk_i) disable iff (!reset_n_i)
		$fell(pulse_reg) |-> $past(pulse_cnt_reg) == PULSE_LAST;
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("trigger pulse width wrong");

	property p_out1_static;
		@(posedge clk_i) disable iff (!reset_n_i)
		(out_cfg_reg[OUT1_LSB +: 2] == OUT1_HIGH) |=> out1_reg;
	endproperty
	a_out1_static: assert property (p_out1_static) else $error("output one not held high");

	property p_rec_delay;
		@(posedge clk_i) disable iff (!reset_n_i)
		$changed(rec_out_reg) |-> $past(rec_cnt_reg) == REC_LAST;
	endproperty
	a_rec_delay: assert property (p_rec_delay) else $error("recording output delay wrong");

	property p_alarm_hold;
		@(posedge clk_i) disable iff (!reset_n_i)
		$changed(alarm_out_reg) |-> $past(alarm_cnt_reg) == DLY_LAST;
	endproperty
	a_alarm_hold: assert property (p_alarm_hold) else $error("alarm changed without delay");

	property p_start;
		@(posedge clk_i) disable iff (!reset_n_i)
		(rec_start && !stop_edge && !ctrl_reg[CTRL_SW_STOP_BIT]) |=> recording_reg;
	endproperty
	a_start: assert property (p_start) else $error("recording did not start");

	property p_stop;
		@(posedge clk_i) disable iff (!reset_n_i)
		stop_edge |=> !recording_reg;
	endproperty
	a_stop: assert property (p_stop) else $error("recording did not stop");

	property p_narrow_mode;
		@(posedge clk_i) disable iff (!reset_n_i)
		!ctrl_reg[CTRL_WIDE_BIT] [*2] |-> live[0] == 32'h0 && live[1] == 32'h0;
	endproperty
	a_narrow_mode: assert property (p_narrow_mode) else $error("counter ran in narrow mode");

	property p_gate;
		@(posedge clk_i) disable iff (!reset_n_i)
		gate_tick |=> result[0] == $past(live[0]);
	endproperty
	a_gate: assert property (p_gate) else $error("result not latched at gate");
endmodule

// file: verif/encoder_model.sv
`timescale 1ns/1ps
module encoder_model (
	input wire logic clk_i,
	output logic [15:0] pins_o
);
	// Each level stays 100 ns, the shortest pulse the pins accept
	localparam int HOLD = 20;

	// Pins rest low until a task moves them
	initial pins_o = 16'h0000;

	// One pin to one level, then held
	task automatic hit(input int p, input logic v);
		pins_o[p] <= v;
		repeat (HOLD) @(posedge clk_i);
	endtask

	// Whole high-low pulses on one pin
	task automatic pulse(input int p, input int n);
		repeat (n) begin
			hit(p, 1'b1);
			hit(p, 1'b0);
		end
	endtask

	// Phases a quarter cycle apart; A leads when counting up
	task automatic quad(input int p, input int n, input logic up);
		logic [1:0] s;
		s = {pins_o[p+1], pins_o[p]};
		repeat (n) begin
			s = up ? {s[0], ~s[1]} : {~s[0], s[1]};
			pins_o[p] <= s[0];
			pins_o[p+1] <= s[1];
			repeat (HOLD) @(posedge clk_i);
		end
	endtask
endmodule

// file: verif/event_timer_counter_unit_bench.sv
`timescale 1ns/1ps
module event_timer_counter_unit_bench;
	import event_timer_pkg::*;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata;
	logic [15:0] pins;
	logic [5:0] trig = 6'h00;
	logic [5:0] alarm = 6'h00;
	logic stick = 1'b0;
	logic o1;
	logic o2;
	logic rec;
	int errors = 0;
	int checks = 0;
	int cyc = 0;

	// Clock, 5 ns period
	always #2.5 clk_i = ~clk_i;

	encoder_model i_src (.clk_i(clk_i), .pins_o(pins));

	// Short delay keeps trigger and alarm runs brief
	event_timer_counter_unit #(.EVT_DELAY(20)) i_dut (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .evt_pin_i(pins),
		.chan_trig_i(trig), .chan_alarm_i(alarm), .sample_tick_i(stick),
		.out_evt1_o(o1), .out_evt2_o(o2), .recording_o(rec)
	);

	task automatic tally_and_finish();
		if (errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Hang guard, well above the whole sequence
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Wait, then step past the edge so outputs have settled
	task automatic tk(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	// Read data stand from the cycle after the strobe until the next read strobe
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata, e);
	endtask

	function automatic logic [7:0] ca(input logic [7:0] k, input logic [7:0] o);
		return ADDR_CNT_BASE + CNT_STRIDE * k + o;
	endfunction

	task automatic st();
		@(posedge clk_i);
		stick <= 1'b1;
		@(posedge clk_i);
		stick <= 1'b0;
		tk(3);
	endtask

	task automatic t_regs();
		rc(ADDR_CTRL, CTRL_RESET);
		rc(ADDR_GATE, GATE_RESET);
		rc(ca(0, CNT_MAX_OFS), MAX_RESET);
		rc(ADDR_STATUS, 32'h0);
		rc(8'hfc, 32'h0);
	endtask

	task automatic t_out();
		wr(ADDR_EVT_INV, 32'h00a1);
		tk(4);
		rc(ADDR_STATUS, 32'h00a1);
		i_src.hit(3, 1'b1);
		rc(ADDR_STATUS, 32'h00a9);
		i_src.hit(3, 1'b0);
		wr(ADDR_EVT_INV, 32'h0);
		wr(ADDR_OUT_CFG, 32'h5);
		tk(3);
		chk({31'h0, o1}, 32'h1);
		chk({31'h0, o2}, 32'h1);
		wr(ADDR_OUT_CFG, 32'hc);
		tk(3);
		chk({31'h0, o1}, 32'h0);
		chk({31'h0, o2}, 32'h0);
	endtask

	task automatic t_trig();
		wr(ADDR_OUT_CFG, 32'h2);
		@(posedge clk_i);
		trig <= 6'h04;
		@(posedge clk_i);
		trig <= 6'h00;
		tk(15);
		chk({31'h0, o1}, 32'h0);
		tk(12);
		chk({31'h0, o1}, 32'h1);
		tk(2500);
		chk({31'h0, o1}, 32'h1);
		tk(100);
		chk({31'h0, o1}, 32'h0);
	endtask

	task automatic t_alarm();
		wr(ADDR_OUT_CFG, 32'h3);
		alarm <= 6'h20;
		tk(12);
		chk({31'h0, o1}, 32'h0);
		tk(15);
		chk({31'h0, o1}, 32'h1);
		alarm <= 6'h00;
		tk(12);
		chk({31'h0, o1}, 32'h1);
		tk(15);
		chk({31'h0, o1}, 32'h0);
	endtask

	// Recording edges, delayed output two, start and first-pulse clears
	task automatic t_rec();
		wr(ADDR_CTRL, 32'h1);
		wr(ADDR_OUT_CFG, 32'h8);
		wr(ca(0, CNT_CFG_OFS), 32'h20);
		i_src.pulse(0, 2);
		rc(ca(0, CNT_LIVE_OFS), 32'h2);
		i_src.hit(14, 1'b1);
		chk({31'h0, rec}, 32'h1);
		tk(65);
		chk({31'h0, o2}, 32'h0);
		tk(15);
		chk({31'h0, o2}, 32'h1);
		i_src.pulse(2, 1);
		rc(ca(0, CNT_LIVE_OFS), 32'h0);
		i_src.pulse(0, 3);
		i_src.pulse(2, 1);
		rc(ca(0, CNT_LIVE_OFS), 32'h3);
		wr(ca(0, CNT_CFG_OFS), 32'h10);
		i_src.hit(15, 1'b1);
		chk({31'h0, rec}, 32'h0);
		i_src.hit(14, 1'b0);
		i_src.hit(15, 1'b0);
		wr(ADDR_CTRL, 32'h3);
		i_src.hit(14, 1'b1);
		chk({31'h0, rec}, 32'h0);
		i_src.hit(14, 1'b0);
		chk({31'h0, rec}, 32'h1);
		rc(ca(0, CNT_LIVE_OFS), 32'h0);
	endtask

	// Direction, manual clear, disabled counters, every-pulse and inverted reset
	task automatic t_bi();
		wr(ca(0, CNT_CFG_OFS), 32'h1);
		wr(ADDR_CNT_CMD, 32'h1);
		i_src.pulse(0, 3);
		i_src.pulse(2, 1);
		rc(ca(0, CNT_LIVE_OFS), 32'h3);
		i_src.hit(1, 1'b1);
		i_src.pulse(0, 5);
		rc(ca(0, CNT_LIVE_OFS), 32'hffff_fffe);
		wr(ADDR_CNT_CMD, 32'h1);
		rc(ca(0, CNT_LIVE_OFS), 32'h0);
		wr(ADDR_CTRL, 32'h2);
		i_src.pulse(0, 2);
		rc(ca(0, CNT_LIVE_OFS), 32'h0);
		wr(ADDR_CTRL, 32'h3);
		wr(ca(0, CNT_CFG_OFS), 32'h30);
		i_src.pulse(0, 4);
		rc(ca(0, CNT_LIVE_OFS), 32'h4);
		i_src.pulse(2, 1);
		rc(ca(0, CNT_LIVE_OFS), 32'h0);
		i_src.pulse(0, 2);
		i_src.pulse(2, 1);
		rc(ca(0, CNT_LIVE_OFS), 32'h0);
		wr(ca(0, CNT_CFG_OFS), 32'h70);
		i_src.hit(2, 1'b1);
		i_src.pulse(0, 3);
		rc(ca(0, CNT_LIVE_OFS), 32'h3);
		i_src.hit(2, 1'b0);
		rc(ca(0, CNT_LIVE_OFS), 32'h0);
		i_src.hit(1, 1'b0);
	endtask

	// Quadrature on counter one, then angle wrap and gated result
	task automatic t_quad_angle();
		wr(ca(1, CNT_CFG_OFS), 32'h2);
		wr(ADDR_CNT_CMD, 32'h2);
		i_src.quad(4, 8, 1'b1);
		rc(ca(1, CNT_LIVE_OFS), 32'h8);
		i_src.quad(4, 3, 1'b0);
		rc(ca(1, CNT_LIVE_OFS), 32'h5);
		wr(ca(0, CNT_MAX_OFS), 32'h4);
		wr(ca(0, CNT_CFG_OFS), 32'h3);
		i_src.pulse(2, 1);
		i_src.pulse(0, 5);
		rc(ca(0, CNT_LIVE_OFS), 32'h1);
		st();
		rc(ca(0, CNT_RES_OFS), 32'h1);
		i_src.pulse(0, 2);
		rc(ca(0, CNT_RES_OFS), 32'h1);
		st();
		rc(ca(0, CNT_RES_OFS), 32'h3);
		i_src.pulse(2, 1);
		rc(ca(0, CNT_LIVE_OFS), 32'h0);
		wr(ADDR_GATE, 32'h0);
		rc(ADDR_GATE, 32'h1);
		// Frequency mode: live count restarts at every gate, result holds the edges
		wr(ca(1, CNT_CFG_OFS), 32'h4);
		i_src.hit(4, 1'b0);
		st();
		i_src.pulse(4, 3);
		st();
		rc(ca(1, CNT_RES_OFS), 32'h3);
		rc(ca(1, CNT_LIVE_OFS), 32'h0);
	endtask

	initial begin
		repeat (3) @(posedge clk_i);
		reset_n_i <= 1'b1;
		t_regs();
		t_out();
		t_trig();
		t_alarm();
		t_rec();
		t_bi();
		t_quad_angle();
		tally_and_finish();
	end
endmodule
